/* src/adc_pm_device.sv */
// Converter end: power-mode sequencer driven by the serial link.
`timescale 1ns/10ps
// Behaviour
// - Two-bit field selects one of four behaviours
// - Auto modes power down on sixteenth rise
// - Auto modes wake on first falling clock
// - Mode 00: chip select level controls power
// - Mode 00: select high aborts conversion
// - Power-on mode field is 00
// - Wake takes 1 us standby, 5 us shutdown
// - Host waits 5 us before sample edge; the host here allows lead_cycles plus four half periods, under 3 us
// - Second rising edge samples, starts conversion
// - Host may use mode 01 then convert again
// - Mode 01 stays powered always
// - First eight clocks load control register
// - Host gives sixteen clocks per transfer
// - Mode 01 accepts conversion on next select
// - Mode 10 full shutdown after conversion
// - Mode 10 host waits 5 us; the host here gives 27 cycles from first fall to sample edge
// - Fast clocks: host toggles via mode 01
// - Host may hold data input low
// - Mode 11 standby after conversion
module adc_pm_device
  import adc_pm_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            arst_n,
  adc_pm_link.device           link,
  input  wire logic [11:0]     sample_data,
  output logic      [1:0]      power_mode,
  output power_state_type      power_state,
  output logic                 ready,
  output logic                 converting,
  output logic                 sample_strobe,
  output logic                 abort_strobe
);

  // All state of the converter end.
  typedef struct packed {
    logic [1:0]      cs_sync;      // Chip select synchroniser.
    logic [1:0]      sclk_sync;    // Serial clock synchroniser.
    logic [1:0]      din_sync;     // Data input synchroniser.
    logic            cs_prev;      // Last synchronised chip select.
    logic            sclk_prev;    // Last synchronised serial clock.
    logic [4:0]      rise_count;   // Rising serial clock edges since select fell.
    logic            seen_fall;    // A falling serial edge came in this frame.
    logic [7:0]      ctrl_shift;   // Control word being shifted in.
    logic [1:0]      mode;         // Active power mode field.
    power_state_type pstate;       // Power state.
    logic [9:0]      wake_count;   // Cycles left until powered.
    logic            conv;         // Conversion in progress.
    logic [15:0]     out_shift;    // Result word being shifted out.
    logic            dout;         // Registered serial output.
    logic            sample;       // One-cycle sample pulse.
    logic            abort;        // One-cycle abort pulse.
  } dev_state_type;

  dev_state_type state;       // Registered state.
  dev_state_type next_state;  // Next value of the state.

  // Start waking toward full power; standby wakes faster because the reference stays up.
  function automatic dev_state_type begin_wake(input dev_state_type s);
    dev_state_type r;
    r = s;
    if (s.pstate == PWR_SHUTDOWN || s.pstate == PWR_STANDBY)
    begin
      r.wake_count = (s.pstate == PWR_STANDBY) ? WAKE_STANDBY_CYCLES : WAKE_SHUTDOWN_CYCLES;
      r.pstate     = PWR_WAKING;
    end
    return r;
  endfunction

  // Local edge and level terms, all from synchronised copies only.
  logic cs_low;     // Synchronised chip select is asserted.
  logic cs_fall;    // Chip select just went low.
  logic cs_rise;    // Chip select just went high.
  logic sclk_rise;  // Serial clock rising edge seen.
  logic sclk_fall;  // Serial clock falling edge seen.

  assign cs_low    = ~state.cs_sync[1];
  assign cs_fall   = state.cs_prev & ~state.cs_sync[1];
  assign cs_rise   = ~state.cs_prev & state.cs_sync[1];
  assign sclk_rise = ~state.sclk_prev & state.sclk_sync[1] & cs_low;
  assign sclk_fall = state.sclk_prev & ~state.sclk_sync[1] & cs_low;

  // Next-state logic: link decoding, control loading and power sequencing.
  always_comb
  begin
    next_state           = state;
    next_state.cs_sync   = {state.cs_sync[0], link.cs_n};
    next_state.sclk_sync = {state.sclk_sync[0], link.sclk};
    next_state.din_sync  = {state.din_sync[0], link.din};
    next_state.cs_prev   = state.cs_sync[1];
    next_state.sclk_prev = state.sclk_sync[1];
    next_state.sample    = 1'b0;
    next_state.abort     = 1'b0;

    // Count down a wake-up in progress.
    if (state.pstate == PWR_WAKING)
    begin
      if (state.wake_count <= 10'h001)
      begin
        next_state.pstate = PWR_ON;
      end
      else
      begin
        next_state.wake_count = state.wake_count - 10'h001;
      end
    end

    if (cs_fall)
    begin
      // A new frame starts; chip-select mode starts its wake-up at once.
      next_state.rise_count = 5'h00;
      next_state.seen_fall  = 1'b0;
      next_state.out_shift  = 16'h0000;
      if (state.mode == MODE_CS_CONTROLLED)
      begin
        next_state = begin_wake(next_state);
      end
    end
    else if (cs_rise)
    begin
      // Leaving mid-conversion in mode 00 abandons it.
      if (state.mode == MODE_CS_CONTROLLED)
      begin
        next_state.abort  = state.conv;
        next_state.conv   = 1'b0;
        next_state.pstate = PWR_SHUTDOWN;
      end
    end
    else if (sclk_fall)
    begin
      // First falling edge wakes the auto modes.
      if (!state.seen_fall && state.mode[1])
      begin
        next_state = begin_wake(next_state);
      end
      next_state.seen_fall = 1'b1;
      next_state.out_shift = {state.out_shift[14:0], 1'b0};
    end
    else if (sclk_rise && state.rise_count < EDGES_PER_FRAME)
    begin
      next_state.rise_count = state.rise_count + 5'h01;
      // Control word shifts on the first eight rising edges.
      if (state.rise_count < 5'(CTRL_BITS))
      begin
        next_state.ctrl_shift = {state.ctrl_shift[6:0], state.din_sync[1]};
        if (state.rise_count == 5'(CTRL_BITS - 1))
        begin
          // The last bit only lands in this cycle, so the field is picked from the completed word.
          next_state.mode = {next_state.ctrl_shift[MODE_HIGH_POS], next_state.ctrl_shift[MODE_LOW_POS]};
        end
      end
      // Second rising edge holds the input and starts conversion.
      if (state.rise_count + 5'h01 == SAMPLE_EDGE)
      begin
        next_state.conv      = 1'b1;
        next_state.sample    = 1'b1;
        // Two leading zeros have already gone out, so the word is loaded one bit in.
        next_state.out_shift = {3'h0, sample_data, 1'b0};
      end
      // Sixteenth rising edge ends the conversion and powers down auto modes.
      if (state.rise_count + 5'h01 == EDGES_PER_FRAME)
      begin
        next_state.conv = 1'b0;
        if (next_state.mode == MODE_AUTO_SHUTDOWN)
        begin
          next_state.pstate = PWR_SHUTDOWN;
        end
        else if (next_state.mode == MODE_AUTO_STANDBY)
        begin
          next_state.pstate = PWR_STANDBY;
        end
      end
    end

    // Always-on mode forces full power regardless of chip select.
    if (next_state.mode == MODE_ALWAYS_ON)
    begin
      next_state.pstate = PWR_ON;
    end
    next_state.dout = next_state.out_shift[15];
  end

  // State register; power-on leaves the field in chip-select mode.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state        <= '0;
      state.cs_sync <= 2'h3;
      state.cs_prev <= 1'b1;
      state.sclk_sync <= 2'h3;  // Serial clock idles high; matching it avoids a false edge after reset.
      state.sclk_prev <= 1'b1;
      state.mode   <= MODE_RESET;
      state.pstate <= PWR_SHUTDOWN;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign link.dout      = state.dout;
  assign link.dout_oe_n = state.cs_sync[1];
  assign power_mode     = state.mode;
  assign power_state    = state.pstate;
  assign ready          = (state.pstate == PWR_ON);
  assign converting     = state.conv;
  assign sample_strobe  = state.sample;
  assign abort_strobe   = state.abort;

endmodule

/* src/adc_pm_pkg.sv */
// Package with the constants and types shared by both ends of the power-mode link.
package adc_pm_pkg;

  // Power mode field codes.
  localparam logic [1:0] MODE_CS_CONTROLLED = 2'h0;  // Shutdown follows chip select.
  localparam logic [1:0] MODE_ALWAYS_ON     = 2'h1;  // Never powers down.
  localparam logic [1:0] MODE_AUTO_SHUTDOWN = 2'h2;  // Full shutdown after each conversion.
  localparam logic [1:0] MODE_AUTO_STANDBY  = 2'h3;  // Standby after each conversion.
  localparam logic [1:0] MODE_RESET         = 2'h0;  // Power-on value of the field.

  // Control word layout: eight bits shifted in first, most significant first.
  localparam int CTRL_BITS      = 8;
  localparam int MODE_HIGH_POS  = 1;  // Position of power_mode_high_bit in the control word.
  localparam int MODE_LOW_POS   = 0;  // Position of power_mode_low_bit in the control word.

  // Serial clock edge counts within one transfer.
  localparam logic [4:0] EDGES_PER_FRAME = 5'h10;  // Sixteen serial clocks per transfer.
  localparam logic [4:0] SAMPLE_EDGE     = 5'h02;  // Rising edge that samples the input.
  localparam logic [4:0] RESULT_BITS     = 5'h10;  // Bits shifted out per transfer.

  // Wake-up times in nanoseconds and their cycle counts at 100 MHz.
  localparam int CLK_PERIOD_NS      = 10;
  localparam int WAKE_STANDBY_NS    = 1000;
  localparam int WAKE_SHUTDOWN_NS   = 5000;
  localparam logic [9:0] WAKE_STANDBY_CYCLES  = 10'((WAKE_STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] WAKE_SHUTDOWN_CYCLES = 10'((WAKE_SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Host side: half period of the generated serial clock in system cycles, less one.
  localparam logic [7:0] SCLK_HALF_CYCLES = 8'h08;

  // Power states of the converter.
  typedef enum logic [1:0] {
    PWR_SHUTDOWN,
    PWR_STANDBY,
    PWR_WAKING,
    PWR_ON
  } power_state_type;

  // Host transfer states.
  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_SELECT,
    HOST_SHIFT,
    HOST_DONE
  } host_state_type;

endpackage

/* src/adc_pm_link.sv */
// Interface carrying the serial link between the host master and the converter.
`timescale 1ns/10ps
interface adc_pm_link;
  logic cs_n;      // Chip select, active low, driven by the host.
  logic sclk;      // Serial clock, driven by the host.
  logic din;       // Serial data into the converter.
  logic dout;      // Serial data out of the converter.
  logic dout_oe_n; // Output enable of dout, low while the converter drives it.

  modport device (input cs_n, input sclk, input din, output dout, output dout_oe_n);
  modport host   (output cs_n, output sclk, output din, input dout, input dout_oe_n);
endinterface

/* src/adc_pm_host.sv */
// Host end: serial master that runs sixteen-clock transfers carrying a control byte.
`timescale 1ns/10ps
module adc_pm_host
  import adc_pm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  adc_pm_link.host         link,
  input  wire logic        start,
  input  wire logic [7:0]  ctrl_word,
  input  wire logic [7:0]  lead_cycles,
  output logic             busy,
  output logic             done,
  output logic [15:0]      result
);

  // All state of the host end.
  typedef struct packed {
    host_state_type st;        // Transfer phase.
    logic [7:0]     div;       // Half-period or lead-time counter.
    logic [4:0]     bits;      // Completed serial clocks.
    logic [7:0]     ctrl;      // Control byte left to send.
    logic           cs_n;      // Chip select output.
    logic           sclk;      // Serial clock output.
    logic [1:0]     dout_sync; // Synchroniser for returning data.
    logic [15:0]    rx;        // Received word.
    logic           done;      // One-cycle completion pulse.
  } host_reg_type;

  host_reg_type state;       // Registered state.
  host_reg_type next_state;  // Next value of the state.

  // Sequencer: lead time after select delays the first clock fall; at most 255 cycles, it is shorter than the shutdown wake-up.
  always_comb
  begin
    next_state           = state;
    next_state.dout_sync = {state.dout_sync[0], link.dout};
    next_state.done      = 1'b0;
    unique case (state.st)
      HOST_IDLE:
      begin
        if (start)
        begin
          next_state.ctrl = ctrl_word;
          next_state.cs_n = 1'b0;
          next_state.div  = lead_cycles;
          next_state.bits = 5'h00;
          next_state.st   = HOST_SELECT;
        end
      end
      HOST_SELECT:
      begin
        if (state.div == 8'h00)
        begin
          next_state.div = SCLK_HALF_CYCLES;
          next_state.st  = HOST_SHIFT;
        end
        else
        begin
          next_state.div = state.div - 8'h01;
        end
      end
      HOST_SHIFT:
      begin
        // The clock idles high so the first edge is falling; data changes on each later falling edge.
        if (state.div == 8'h00)
        begin
          next_state.div  = SCLK_HALF_CYCLES;
          next_state.sclk = ~state.sclk;
          if (!state.sclk)
          begin
            next_state.bits = state.bits + 5'h01;
            next_state.rx   = {state.rx[14:0], state.dout_sync[1]};
            if (state.bits + 5'h01 == RESULT_BITS)
            begin
              next_state.st = HOST_DONE;
            end
          end
          else if (state.bits != 5'h00)
          begin
            next_state.ctrl = {state.ctrl[6:0], 1'b0};
          end
        end
        else
        begin
          next_state.div = state.div - 8'h01;
        end
      end
      HOST_DONE:
      begin
        next_state.cs_n = 1'b1;
        next_state.done = 1'b1;
        next_state.st   = HOST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state      <= '0;
      state.st   <= HOST_IDLE;
      state.cs_n <= 1'b1;
      state.sclk <= 1'b1;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign link.cs_n = state.cs_n;
  assign link.sclk = state.sclk;
  assign link.din  = state.ctrl[7];
  assign busy      = (state.st != HOST_IDLE);
  assign done      = state.done;
  assign result    = state.rx;

endmodule

/* verification/adc_pm_asserts.sv */
// Concurrent checks on the main link and on the converter's power outputs.
`timescale 1ns/10ps
module adc_pm_asserts
  import adc_pm_pkg::*;
(
  input wire logic            clk,
  input wire logic            arst_n,
  input wire logic            cs_n,
  input wire logic            sclk,
  input wire logic [1:0]      power_mode,
  input wire power_state_type power_state,
  input wire logic            ready,
  input wire logic            converting,
  input wire logic            sample_strobe
);
  // Slack of four cycles covers the two-flop pin synchronisers.
  localparam int WAKE_MAX = int'(WAKE_SHUTDOWN_CYCLES) + 4;

  logic [4:0]  rise_cnt; // Serial clock rises seen since chip select fell.
  logic        sclk_q;   // Serial clock one cycle ago.
  logic        cs_q;     // Chip select one cycle ago.
  logic [10:0] wake_cnt; // Cycles spent in the current wake-up.

  // Counts frame rises and wake cycles; clearing on the select fall keeps the count visible after the frame.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rise_cnt <= 5'h00;
      sclk_q   <= 1'b1;
      cs_q     <= 1'b1;
      wake_cnt <= 11'h000;
    end
    else
    begin
      sclk_q   <= sclk;
      cs_q     <= cs_n;
      wake_cnt <= (power_state == PWR_WAKING) ? wake_cnt + 11'h001 : 11'h000;
      if (!cs_n && cs_q)
        rise_cnt <= 5'h00;
      else if (!cs_n && sclk && !sclk_q)
        rise_cnt <= rise_cnt + 5'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  cs_shutdown_a : assert property ((power_mode == MODE_CS_CONTROLLED) && $rose(cs_n) |-> ##[1:6] power_state == PWR_SHUTDOWN)
    else $error("select rise in mode 00 left the converter powered");
  cs_wake_a : assert property ((power_mode == MODE_CS_CONTROLLED) && (power_state == PWR_SHUTDOWN) && $fell(cs_n) |-> ##[1:6] power_state == PWR_WAKING)
    else $error("select fall in mode 00 did not start the wake-up");
  always_on_a : assert property ((power_mode == MODE_ALWAYS_ON) && ($past(power_mode, 2) == MODE_ALWAYS_ON) |-> ready)
    else $error("always powered mode lost ready");
  auto_shutdown_a : assert property ($fell(converting) && (power_mode == MODE_AUTO_SHUTDOWN) |-> ##[0:3] power_state == PWR_SHUTDOWN)
    else $error("no full shutdown after conversion in mode 10");
  auto_standby_a : assert property ($fell(converting) && (power_mode == MODE_AUTO_STANDBY) |-> ##[0:3] power_state == PWR_STANDBY)
    else $error("no standby after conversion in mode 11");
  sample_convert_a : assert property (sample_strobe |=> converting)
    else $error("sampling did not start a conversion");
  mode_load_a : assert property ($changed(power_mode) |-> !cs_n)
    else $error("power mode changed outside a transfer");
  frame_length_a : assert property ($rose(cs_n) |-> ##1 rise_cnt == 5'h10)
    else $error("transfer did not carry sixteen clocks");
  wake_time_a : assert property (wake_cnt <= 11'(WAKE_MAX))
    else $error("wake-up ran longer than the shutdown wake time");

  sample_c  : cover property (sample_strobe);
  standby_c : cover property ($rose(power_state == PWR_STANDBY));
  wake_c    : cover property ($fell(power_state == PWR_WAKING));
endmodule

/* verification/adc_power_mode_sequencer_tb_top.sv */
// Self-checking testbench joining host and converter, plus a bench-driven second converter.
`timescale 1ns/10ps
module adc_power_mode_sequencer_tb_top
  import adc_pm_pkg::*;
;
  localparam int LIMIT = 20000; // Cycle ceiling, several times what the tests need.

  logic            clk;           // System clock.
  logic            arst_n;        // Reset, active low.
  logic            start;         // Host transfer request.
  logic [7:0]      ctrl_word;     // Control byte sent by the host.
  logic [7:0]      lead_cycles;   // Host lead time before the first clock fall.
  logic [11:0]     sample_data;   // Value both converters sample.
  logic            busy;          // Host busy.
  logic            done;          // Host transfer done.
  logic [15:0]     result;        // Word received by the host.
  logic [1:0]      power_mode;    // Main converter mode field.
  logic [1:0]      power_mode_b;  // Second converter mode field.
  power_state_type power_state;   // Main converter power state.
  power_state_type power_state_b; // Second converter power state.
  logic            ready;         // Main converter ready.
  logic            converting;    // Main converter converting.
  logic            sample_strobe; // Main converter sample pulse.
  logic            abort_b;       // Second converter abort pulse.
  int              err_count;     // Mismatches seen.
  int              n_tests;       // Comparisons made.
  int              cyc;           // Cycles since time zero.
  int              wcnt;          // Running wake-up length.
  int              wake_len;      // Length of the last finished wake-up.

  adc_pm_link link ();
  adc_pm_link link_b ();

  adc_pm_host i_adc_pm_host (.clk(clk), .arst_n(arst_n), .link(link), .start(start), .ctrl_word(ctrl_word),
    .lead_cycles(lead_cycles), .busy(busy), .done(done), .result(result));
  adc_pm_device i_adc_pm_device (.clk(clk), .arst_n(arst_n), .link(link), .sample_data(sample_data),
    .power_mode(power_mode), .power_state(power_state), .ready(ready), .converting(converting),
    .sample_strobe(sample_strobe), .abort_strobe());
  adc_pm_device i_adc_pm_device_b (.clk(clk), .arst_n(arst_n), .link(link_b), .sample_data(sample_data),
    .power_mode(power_mode_b), .power_state(power_state_b), .ready(), .converting(), .sample_strobe(),
    .abort_strobe(abort_b));
  adc_pm_asserts i_adc_pm_asserts (.clk(clk), .arst_n(arst_n), .cs_n(link.cs_n), .sclk(link.sclk),
    .power_mode(power_mode), .power_state(power_state), .ready(ready), .converting(converting),
    .sample_strobe(sample_strobe));

  // Free-running 100 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Times each wake-up of the main converter; the length is kept once the state moves on.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (power_state === PWR_WAKING)
      wcnt <= wcnt + 1;
    else if (wcnt != 0)
    begin
      wake_len <= wcnt;
      wcnt     <= 0;
    end
    if (cyc == LIMIT)
    begin
      err_count++;
      $display("mismatch at %0t: cycle limit reached", $time);
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_state(input power_state_type got, input power_state_type exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %s expected %s", $time, what, got.name(), exp.name());
    end
  endtask

  task automatic check_count(input int got, input int exp, input int tol, input string what);
    n_tests++;
    if (got < exp - tol || got > exp + tol)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  // One host transfer; waits for done under a bound, then lets the select rise reach the converter.
  task automatic run_frame(input logic [7:0] ctrl, input logic [7:0] lead);
    int i;
    @(posedge clk);
    start       <= 1'b1;
    ctrl_word   <= ctrl;
    lead_cycles <= lead;
    @(posedge clk);
    start <= 1'b0;
    for (i = 0; i < 3000 && done !== 1'b1; i++)
      @(negedge clk);
    if (done !== 1'b1)
    begin
      err_count++;
      $display("mismatch at %0t: host transfer did not finish", $time);
    end
    repeat (8) @(posedge clk);
  endtask

  // Bench plays the host on the second link; the long lead lets a full shutdown wake-up be timed.
  task automatic bang_b(input logic [7:0] ctrl, input int rises, input int lead, output int woke);
    int i;
    woke = 0;
    @(posedge clk);
    link_b.cs_n <= 1'b0;
    repeat (lead)
    begin
      @(negedge clk);
      if (power_state_b === PWR_WAKING)
        woke++;
    end
    @(posedge clk);
    for (i = 0; i < rises; i++)
    begin
      link_b.sclk <= 1'b0;
      link_b.din  <= (i < 8) ? ctrl[3'(7 - i)] : 1'b0;
      repeat (9) @(posedge clk);
      link_b.sclk <= 1'b1;
      repeat (9) @(posedge clk);
    end
    link_b.cs_n <= 1'b1;
  endtask

  task automatic t_reset();
    check_word({14'h0, power_mode}, {14'h0, MODE_RESET}, "reset mode");
    check_state(power_state, PWR_SHUTDOWN, "reset state");
    $display("test reset done");
  endtask

  // Back-to-back transfers holding the always powered code.
  task automatic t_always_on();
    run_frame(8'h01, 8'h04);
    run_frame(8'h01, 8'h04);
    check_word({14'h0, power_mode}, {14'h0, MODE_ALWAYS_ON}, "mode 01 load");
    check_state(power_state, PWR_ON, "mode 01 power");
    check_word(result, {4'h0, sample_data}, "mode 01 result");
    $display("test always_on done");
  endtask

  // Mode 00 shuts down on select rise; recovery through code 01 and a second conversion.
  task automatic t_cs_mode();
    run_frame(8'h00, 8'h04);
    check_state(power_state, PWR_SHUTDOWN, "mode 00 after select rise");
    run_frame(8'h01, 8'h04);
    run_frame(8'h01, 8'h04);
    check_word(result, {4'h0, sample_data}, "result after recovery");
    $display("test cs_mode done");
  endtask

  // Automatic shutdown, then automatic standby and its short wake-up.
  task automatic t_auto();
    run_frame(8'h02, 8'h04);
    check_state(power_state, PWR_SHUTDOWN, "mode 10 after conversion");
    // Fast clocks: pass through code 01, then restore code 10 during the second conversion.
    run_frame(8'h01, 8'h04);
    run_frame(8'h02, 8'h04);
    check_word(result, {4'h0, sample_data}, "result after mode 10 recovery");
    check_state(power_state, PWR_SHUTDOWN, "mode 10 restored");
    run_frame(8'h03, 8'h04);
    run_frame(8'h03, 8'h04);
    check_state(power_state, PWR_STANDBY, "mode 11 after conversion");
    check_count(wake_len, int'(WAKE_STANDBY_CYCLES), 3, "standby wake length");
    $display("test auto done");
  endtask

  // Second converter: timed shutdown wake-up, then select raised mid-conversion.
  task automatic t_abort();
    int  woke;
    int  i;
    logic seen;
    seen = 1'b0;
    bang_b(8'h00, 4, 600, woke);
    for (i = 0; i < 10; i++)
    begin
      @(negedge clk);
      if (abort_b === 1'b1)
        seen = 1'b1;
    end
    check_count(woke, int'(WAKE_SHUTDOWN_CYCLES), 4, "shutdown wake length");
    check_word({15'h0, seen}, 16'h0001, "abort pulse");
    check_state(power_state_b, PWR_SHUTDOWN, "state after abort");
    check_word({14'h0, power_mode_b}, {14'h0, MODE_CS_CONTROLLED}, "mode after abort");
    $display("test abort done");
  endtask

  // Main sequence.
  initial
  begin
    arst_n      = 1'b0;
    start       = 1'b0;
    ctrl_word   = 8'h00;
    lead_cycles = 8'h04;
    sample_data = 12'ha5c;
    link_b.cs_n = 1'b1;
    link_b.sclk = 1'b1;
    link_b.din  = 1'b0;
    err_count   = 0;
    n_tests     = 0;
    cyc         = 0;
    wcnt        = 0;
    wake_len    = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_always_on();
    t_cs_mode();
    t_auto();
    t_abort();
    finish_test();
  end
endmodule
